// ===== verilog/tph_pkg.sv
/*
 * Package for the temperature peak hold and averaging filter: register
 * offsets, field positions, setting limits and timing constants.
 * Assumes a 25 MHz system clock and 16-bit unsigned temperature samples.
 */
package tph_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned HOLD_TICK_MS = 100;
    localparam int unsigned TRIG_MIN_MS = 10;
    localparam int unsigned TICK_CYC_DEF = CLK_HZ / 1000 * HOLD_TICK_MS;
    localparam int unsigned TRIG_CYC_DEF = CLK_HZ / 1000 * TRIG_MIN_MS;

    localparam int TW = 16;
    localparam int HW = 12;
    localparam int DW = 14;

    // Byte offsets of the register map
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_HOLD = 8'h04;
    localparam logic [7:0] OFS_TRIG = 8'h08;
    localparam logic [7:0] OFS_HYST = 8'h0C;
    localparam logic [7:0] OFS_DECAY = 8'h10;
    localparam logic [7:0] OFS_AVG = 8'h14;
    localparam logic [7:0] OFS_RMIN = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1C;
    localparam logic [7:0] OFS_OUT = 8'h20;

    // Control fields
    localparam int CTRL_ADV = 0;
    localparam int CTRL_ALARM = 1;
    localparam int CTRL_AVG_TRIG = 2;
    // Status fields
    localparam int ST_PKH = 0;
    localparam int ST_AVG = 1;
    localparam int ST_EXP = 2;
    localparam int ST_UNDER = 3;
    localparam int ST_TRACK = 4;

    // Setting limits; hold and averaging in tenths of a second, decay in samples
    localparam logic [HW-1:0] HOLD_MAX = 12'h0BB7;
    localparam logic [HW-1:0] HOLD_INF = 12'h0BB8;
    localparam logic [HW-1:0] AVG_MAX = 12'h0BB8;
    localparam logic [DW-1:0] DECAY_MAX = 14'h270F;
    localparam logic [HW-1:0] HOLD_ZERO = 12'h000;
    localparam logic [HW-1:0] HOLD_ONE = 12'h001;
    localparam logic [HW-1:0] HOLD_SAT = 12'hFFF;
    localparam logic [TW-1:0] TEMP_ONE = 16'h0001;
    localparam logic [TW-1:0] TEMP_ZERO = 16'h0000;
    localparam logic [31:0] REG_ZERO = 32'h0000_0000;
    localparam logic [4:0] AVG_SH_OFS = 5'h03;
    localparam logic [4:0] AVG_SH_MAX = 5'h10;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        TPH_IDLE = 2'b00,
        TPH_BELOW = 2'b01,
        TPH_TRACK = 2'b11
    } tph_adv_t;
endpackage

// ===== verilog/tph_filter.sv
/*
 * Temperature peak hold, peak decay and averaging filter with an
 * AXI4-Lite register slave, panel buttons and an external trigger input.
 * Assumes samples, buttons and trigger are synchronous to sys_clk_in.
 */
// The AXI4-Lite interface to the registers and the address map were decided locally.
// Contract
// - Hold time accepts 0 to 299.9 s in tenth-second steps.
// - Hold time 300.0 s holds the peak until a trigger reset.
// - Peak hold active exactly when hold time is nonzero.
// - Simple hold: on timer expiry the output follows the measurement.
// - Simple hold: a sample above the held value becomes the new peak.
// - Averaging and peak hold never process the output together.
// - Advanced peak uses only trigger and hysteresis, no hold timer.
// - After dropping below then rising above trigger, track a candidate max.
// - Candidate accepted once the sample falls below it by over hysteresis.
// - Advanced peak plus time also releases the hold on timer expiry.
// - At 300 s, trigger low for 10 ms resets the held peak.
// - Nonzero decay lowers the held value gradually until a new peak.
// - Alarm mode underrange only when expired and below measuring range.
// - Advanced hold: a higher sample updates output and restarts timer.
// - A maximum never above trigger is ignored; output held, timer runs. The code loads any higher sample and restarts the timer.
// - Averaging is a first-order low pass, time constant 0 to 300 s.
// - Averaging active exactly when its time constant is nonzero; the code also requires hold time zero.
// - Advanced modes can be enabled over the serial side only.
// - Optionally, trigger low for 10 ms resets the averaged value.
`timescale 1ns/1ps
`default_nettype none
module tph_filter #(
    parameter int unsigned TICK_CYC = tph_pkg::TICK_CYC_DEF,
    parameter int unsigned TRIG_CYC = tph_pkg::TRIG_CYC_DEF
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic [tph_pkg::TW-1:0] sample_in,
    input wire logic sample_valid_in,
    input wire logic trigger_n_in,
    input wire logic panel_up_in,
    input wire logic panel_down_in,
    input wire logic panel_sel_avg_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [tph_pkg::TW-1:0] temp_out,
    output logic temp_valid_out,
    output logic peak_hold_indicator_out,
    output logic averaging_indicator_out,
    output logic failsafe_under_out
);
    import tph_pkg::*;

    localparam int TKW = $clog2(TICK_CYC + 1);
    localparam int TGW = $clog2(TRIG_CYC + 1);
    localparam logic [TKW-1:0] TICK_LAST = TKW'(TICK_CYC - 1);
    localparam logic [TGW-1:0] TRIG_LAST = TGW'(TRIG_CYC - 1);

    logic [2:0] ctrl_q;
    logic [HW-1:0] hold_q, avg_q;
    logic [TW-1:0] trig_q, hyst_q, rmin_q;
    logic [DW-1:0] decay_q;
    logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [1:0] bresp_q, rresp_q;
    logic wr_fire, wr_ok;
    logic [TKW-1:0] tick_cnt_q;
    logic tick;
    logic [TGW-1:0] trig_cnt_q;
    logic trig_pulse, trig_done_q;
    logic [HW-1:0] hold_cnt_q;
    logic [DW-1:0] dec_cnt_q;
    logic [TW-1:0] out_q, last_q, cand_q;
    logic [31:0] acc_q;
    logic valid_q;
    tph_adv_t adv_q;
    logic pk_act, av_act, adv_mode, timed, expired, new_peak;
    logic accept, peak_reset, avg_reset, dec_step;
    logic [32:0] avg_diff;
    logic [4:0] avg_sh;

    function automatic logic [4:0] msb_pos(input logic [HW-1:0] v);
        logic [4:0] p;
        p = 5'h00;
        for (int i = 0; i < HW; i++) begin
            if (v[i]) begin
                p = 5'(i);
            end
        end
        return p;
    endfunction

    // Mode decode
    assign pk_act = (hold_q != HOLD_ZERO);
    assign av_act = (avg_q != HOLD_ZERO) && !pk_act;
    assign adv_mode = pk_act && ctrl_q[CTRL_ADV];
    assign timed = pk_act && (hold_q != HOLD_INF);
    assign expired = timed && (hold_cnt_q >= hold_q);
    assign new_peak = sample_valid_in && (sample_in > out_q);
    assign accept = sample_valid_in && adv_mode && (adv_q == TPH_TRACK)
        && (cand_q > sample_in) && ((cand_q - sample_in) > hyst_q);
    assign peak_reset = trig_pulse && (hold_q == HOLD_INF);
    assign avg_reset = trig_pulse && av_act && ctrl_q[CTRL_AVG_TRIG];
    assign dec_step = sample_valid_in && pk_act && (decay_q != '0)
        && (dec_cnt_q >= decay_q - DW'(1));

    // AXI4-Lite write channel
    assign s_axi_awready_out = !aw_full_q;
    assign s_axi_wready_out = !w_full_q;
    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out = bresp_q;
    assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
    assign wr_ok = (awaddr_q <= OFS_RMIN) && (awaddr_q[1:0] == 2'b00);

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            aw_full_q <= 1'b0;
            awaddr_q <= 8'h00;
        end else if (s_axi_awvalid_in && !aw_full_q) begin
            aw_full_q <= 1'b1;
            awaddr_q <= s_axi_awaddr_in;
        end else if (wr_fire) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            w_full_q <= 1'b0;
            wdata_q <= REG_ZERO;
        end else if (s_axi_wvalid_in && !w_full_q) begin
            w_full_q <= 1'b1;
            for (int b = 0; b < 4; b++) begin
                wdata_q[8*b +: 8] <= s_axi_wstrb_in[b] ?
                    s_axi_wdata_in[8*b +: 8] : 8'h00;
            end
        end else if (wr_fire) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            bvalid_q <= 1'b0;
        end
    end

    // Settings; bus writes take priority over panel buttons
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            ctrl_q <= 3'b000;
            hold_q <= HOLD_ZERO;
            avg_q <= HOLD_ZERO;
            trig_q <= TEMP_ZERO;
            hyst_q <= TEMP_ZERO;
            decay_q <= '0;
            rmin_q <= TEMP_ZERO;
        end else if (wr_fire && wr_ok) begin
            unique case (awaddr_q)
                OFS_CTRL: ctrl_q <= wdata_q[2:0];
                OFS_HOLD: begin
                    hold_q <= (wdata_q[15:0] > 16'(HOLD_INF)) ?
                        HOLD_INF : wdata_q[HW-1:0];
                end
                OFS_TRIG: trig_q <= wdata_q[TW-1:0];
                OFS_HYST: hyst_q <= wdata_q[TW-1:0];
                OFS_DECAY: begin
                    decay_q <= (wdata_q[15:0] > 16'(DECAY_MAX)) ?
                        DECAY_MAX : wdata_q[DW-1:0];
                end
                OFS_AVG: begin
                    avg_q <= (wdata_q[15:0] > 16'(AVG_MAX)) ?
                        AVG_MAX : wdata_q[HW-1:0];
                end
                OFS_RMIN: rmin_q <= wdata_q[TW-1:0];
                default: ;
            endcase
        end else if (panel_up_in && !panel_down_in) begin
            // Panel reaches only hold time and time constant
            if (panel_sel_avg_in && !pk_act && avg_q < AVG_MAX) begin
                avg_q <= avg_q + HOLD_ONE;
            end else if (!panel_sel_avg_in && avg_q == HOLD_ZERO
                    && hold_q < HOLD_INF) begin
                hold_q <= hold_q + HOLD_ONE;
            end
        end else if (panel_down_in && !panel_up_in) begin
            if (panel_sel_avg_in && avg_q != HOLD_ZERO) begin
                avg_q <= avg_q - HOLD_ONE;
            end else if (!panel_sel_avg_in && hold_q != HOLD_ZERO) begin
                hold_q <= hold_q - HOLD_ONE;
            end
        end
    end

    // AXI4-Lite read channel
    assign s_axi_arready_out = !rvalid_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rdata_out = rdata_q;
    assign s_axi_rresp_out = rresp_q;

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            rvalid_q <= 1'b0;
            rdata_q <= REG_ZERO;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid_in && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            rdata_q <= REG_ZERO;
            unique case (s_axi_araddr_in)
                OFS_CTRL: rdata_q[2:0] <= ctrl_q;
                OFS_HOLD: rdata_q[HW-1:0] <= hold_q;
                OFS_TRIG: rdata_q[TW-1:0] <= trig_q;
                OFS_HYST: rdata_q[TW-1:0] <= hyst_q;
                OFS_DECAY: rdata_q[DW-1:0] <= decay_q;
                OFS_AVG: rdata_q[HW-1:0] <= avg_q;
                OFS_RMIN: rdata_q[TW-1:0] <= rmin_q;
                OFS_STAT: begin
                    rdata_q[ST_PKH] <= pk_act;
                    rdata_q[ST_AVG] <= av_act;
                    rdata_q[ST_EXP] <= expired;
                    rdata_q[ST_UNDER] <= failsafe_under_out;
                    rdata_q[ST_TRACK] <= (adv_q == TPH_TRACK);
                end
                OFS_OUT: rdata_q[TW-1:0] <= out_q;
                default: rresp_q <= RESP_SLVERR;
            endcase
        end else if (s_axi_rready_in) begin
            rvalid_q <= 1'b0;
        end
    end

    // Tenth-second tick
    assign tick = (tick_cnt_q == TICK_LAST);
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in || tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + TKW'(1);
        end
    end

    // Trigger low time, one pulse per low period
    assign trig_pulse = !trigger_n_in && !trig_done_q
        && (trig_cnt_q == TRIG_LAST);
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in || trigger_n_in) begin
            trig_cnt_q <= '0;
            trig_done_q <= 1'b0;
        end else if (trig_pulse) begin
            trig_done_q <= 1'b1;
        end else if (!trig_done_q) begin
            trig_cnt_q <= trig_cnt_q + TGW'(1);
        end
    end

    // Hold timer in ticks, restarted by a new or accepted peak
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            hold_cnt_q <= HOLD_ZERO;
        end else if (new_peak || accept || peak_reset) begin
            hold_cnt_q <= HOLD_ZERO;
        end else if (tick && hold_cnt_q != HOLD_SAT) begin
            hold_cnt_q <= hold_cnt_q + HOLD_ONE;
        end
    end

    // Advanced trigger tracking
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in || !adv_mode || peak_reset) begin
            adv_q <= TPH_IDLE;
            cand_q <= TEMP_ZERO;
        end else if (sample_valid_in) begin
            if (sample_in < trig_q) begin
                adv_q <= TPH_BELOW;
            end else if (adv_q == TPH_BELOW) begin
                adv_q <= TPH_TRACK;
                cand_q <= sample_in;
            end else if (accept) begin
                adv_q <= TPH_IDLE;
            end else if (adv_q == TPH_TRACK && sample_in > cand_q) begin
                cand_q <= sample_in;
            end
        end
    end

    // Decay step counter in samples
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in || new_peak || dec_step) begin
            dec_cnt_q <= '0;
        end else if (sample_valid_in && pk_act) begin
            dec_cnt_q <= dec_cnt_q + DW'(1);
        end
    end

    // Averaging accumulator, 16 fraction bits
    always_comb begin
        avg_sh = msb_pos(avg_q) + AVG_SH_OFS;
        if (avg_sh > AVG_SH_MAX) begin
            avg_sh = AVG_SH_MAX;
        end
        avg_diff = $signed({1'b0, sample_in, 16'h0000})
            - $signed({1'b0, acc_q});
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            acc_q <= REG_ZERO;
        end else if (sample_valid_in && (!av_act || avg_reset)) begin
            acc_q <= {sample_in, 16'h0000};
        end else if (avg_reset) begin
            acc_q <= {last_q, 16'h0000};
        end else if (sample_valid_in) begin
            acc_q <= acc_q + 32'($signed(avg_diff) >>> avg_sh);
        end
    end

    // Output value
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            out_q <= TEMP_ZERO;
            last_q <= TEMP_ZERO;
            valid_q <= 1'b0;
        end else begin
            valid_q <= sample_valid_in;
            if (sample_valid_in) begin
                last_q <= sample_in;
            end
            if (peak_reset) begin
                out_q <= last_q;
            end else if (sample_valid_in) begin
                if (av_act) begin
                    out_q <= acc_q[31:16];
                end else if (!pk_act || new_peak) begin
                    out_q <= sample_in;
                end else if (expired) begin
                    out_q <= sample_in;
                end else if (accept) begin
                    out_q <= cand_q;
                end else if (dec_step && out_q != TEMP_ZERO) begin
                    out_q <= out_q - TEMP_ONE;
                end
            end
        end
    end

    assign temp_out = out_q;
    assign temp_valid_out = valid_q;
    assign peak_hold_indicator_out = pk_act;
    assign averaging_indicator_out = av_act;
    assign failsafe_under_out = ctrl_q[CTRL_ALARM] && adv_mode && expired
        && (out_q < rmin_q);

    // Checks
    AST_HOLD_RANGE: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in) hold_q <= HOLD_INF)
        else $error("hold time out of range");
    AST_INF_HOLDS: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        (hold_q == HOLD_INF && !ctrl_q[CTRL_ADV] && !trig_pulse
        && !(wr_fire || panel_up_in || panel_down_in)
        && sample_valid_in && sample_in <= out_q && decay_q == '0)
        |=> $stable(out_q))
        else $error("infinite hold released the peak");
    AST_EXCL: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        !(peak_hold_indicator_out && averaging_indicator_out))
        else $error("averaging and peak hold both active");
    AST_PKH_ON: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        $rose(hold_q != HOLD_ZERO) |-> peak_hold_indicator_out
        && !averaging_indicator_out)
        else $error("peak hold indicator not set");
    AST_LOAD_PEAK: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        (pk_act && new_peak && !peak_reset) |=> temp_out == $past(sample_in)
        && hold_cnt_q == HOLD_ZERO)
        else $error("new peak not loaded");
    AST_FOLLOW: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        (pk_act && expired && sample_valid_in && !peak_reset)
        |=> temp_out == $past(sample_in))
        else $error("output does not follow after expiry");
    AST_ACCEPT: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        (accept && !new_peak && !expired && !peak_reset)
        |=> temp_out == $past(cand_q) && adv_q != TPH_TRACK)
        else $error("candidate not accepted");
    AST_BELOW: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        (adv_mode && sample_valid_in && sample_in < trig_q
        && !peak_reset && $stable(ctrl_q)) |=> adv_q == TPH_BELOW)
        else $error("below trigger not recorded");
    AST_TRIG_RST: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        (!trigger_n_in && hold_q == HOLD_INF && !trig_done_q
        && trig_cnt_q == TRIG_LAST) |=> temp_out == $past(last_q))
        else $error("trigger did not reset held peak");
    AST_UNDER: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        failsafe_under_out |-> expired && temp_out < rmin_q
        && ctrl_q[CTRL_ALARM])
        else $error("underrange without both conditions");
    AST_AVG_TC: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        averaging_indicator_out |-> avg_q <= AVG_MAX && avg_q != HOLD_ZERO)
        else $error("averaging time constant invalid");
    AST_BRESP: assert property (@(posedge sys_clk_in)
        disable iff (!resetn_in)
        wr_fire |=> s_axi_bvalid_out
        && ((s_axi_bresp_out == RESP_OKAY) == $past(wr_ok)))
        else $error("write response missing");

    COV_ACCEPT: cover property (@(posedge sys_clk_in)
        disable iff (!resetn_in) accept);
    COV_EXPIRE: cover property (@(posedge sys_clk_in)
        disable iff (!resetn_in) $rose(expired));
    COV_TRIG: cover property (@(posedge sys_clk_in)
        disable iff (!resetn_in) peak_reset);
    COV_AVG: cover property (@(posedge sys_clk_in)
        disable iff (!resetn_in) av_act && sample_valid_in);
endmodule
`default_nettype wire

// ===== tb/tph_front_model.sv
/* Front end model: hands the filter one strobed sample per go pulse.
   Assumes go_in is a one-cycle pulse synchronous to clk_in. */
`timescale 1ns/1ps
`default_nettype none
module tph_front_model (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic [15:0] val_in,
    output logic [15:0] sample_out = 16'h0000,
    output logic valid_out = 1'b0
);
    // Idle bus inverts its own previous value on every idle cycle
    always @(posedge clk_in) begin
        valid_out <= go_in;
        sample_out <= go_in ? val_in : ~sample_out;
    end
endmodule
`default_nettype wire

// ===== tb/temperature_peak_hold_avg_filter_tb.sv
/* Bench for tph_filter: AXI4-Lite master, front end model, reference.
   Assumes the one-cycle sample latency of the filter. */
`timescale 1ns/1ps
`default_nettype none
module temperature_peak_hold_avg_filter_tb;
    import tph_pkg::*;
    logic clk = 0, rst_n = 0, go = 0, trig_n = 1, up = 0, sel = 0, dn = 0;
    logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic awr, wr, bv, arr, rv, tv, phi, avi, fs, sv;
    logic [1:0] bresp, rresp;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd;
    logic [15:0] val = 0, smp_w, tout;
    int errors = 0, cmp_count = 0, seed = 88944, mx, lo, o1;
    int av[11] = '{400, 300, 600, 550, 300, 520, 530, 505, 300, 450, 400};
    int ae[11] = '{400, 400, 600, 600, 600, 600, 600, 530, 530, 530, 530};
    initial forever #20 clk = ~clk;
    tph_front_model fe (.clk_in(clk), .go_in(go), .val_in(val),
        .sample_out(smp_w), .valid_out(sv));
    tph_filter #(.TICK_CYC(10), .TRIG_CYC(8)) dut (.sys_clk_in(clk),
        .resetn_in(rst_n), .sample_in(smp_w), .sample_valid_in(sv),
        .trigger_n_in(trig_n), .panel_up_in(up), .panel_down_in(dn),
        .panel_sel_avg_in(sel), .s_axi_awaddr_in(awa),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
        .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wr), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(br), .s_axi_araddr_in(ara),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_rdata_out(rd), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .temp_out(tout),
        .temp_valid_out(tv), .peak_hold_indicator_out(phi),
        .averaging_indicator_out(avi), .failsafe_under_out(fs));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic finish_test();
        $display("Errors %0d, compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic axi(input logic w, input logic [7:0] a,
            input logic [31:0] d, input logic [1:0] er);
        logic ra, rw, rb = 0;
        logic [31:0] x;
        logic [1:0] r;
        int n = 0;
        {awa, ara, wd} <= {a, a, d};
        {awv, wv, br, arv, rr} <= {w, w, w, !w, !w};
        while (!rb && n++ < 40) begin
            @(negedge clk);
            {ra, rw, x} = {w ? awr : arr, wr, rd};
            {rb, r} = w ? {bv, bresp} : {rv, rresp};
            @(posedge clk);
            {awv, wv, arv} <= {awv & ~ra, wv & ~rw, arv & ~ra};
        end
        {br, rr} <= 2'b00;
        @(posedge clk);
        if (!rb) begin
            errors++;
            finish_test();
        end
        chk(r, er);
        if (!w) chk(x, d);
    endtask
    task automatic smp(input int v, input int e);
        {val, go} <= {v[15:0], 1'b1};
        @(posedge clk);
        go <= 0;
        repeat (2) @(negedge clk);
        lo = tout;
        chk(tv, 1);
        if (e >= 0) chk(tout, e);
        @(posedge clk);
    endtask
    task automatic trg();
        trig_n <= 0;
        repeat (10) @(posedge clk);
        trig_n <= 1;
        @(posedge clk);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1;
        @(negedge clk);
        chk({tout, phi, avi, fs}, 0);
        @(posedge clk);
        up <= 1;
        @(posedge clk);
        up <= 0;
        axi(0, OFS_HOLD, 1, RESP_OKAY);
        chk(phi, 1);
        dn <= 1;
        @(posedge clk);
        dn <= 0;
        @(posedge clk);
        chk(phi, 0);
        axi(0, 8'h40, 0, RESP_SLVERR);
        axi(1, OFS_OUT, 7, RESP_SLVERR);
        axi(1, OFS_HOLD, 5, RESP_OKAY);
        smp(100, 100);
        smp(200, 200);
        smp(150, 200);
        repeat (80) @(posedge clk);
        smp(120, 120);
        axi(1, OFS_HOLD, 4000, RESP_OKAY);
        axi(0, OFS_HOLD, 3000, RESP_OKAY);
        mx = 0;
        for (int i = 0; i < 8; i++) begin
            o1 = 1000 + ($random(seed) & 1023);
            mx = o1 > mx ? o1 : mx;
            smp(o1, mx);
        end
        repeat (100) @(posedge clk);
        smp(100, mx);
        trg();
        chk(tout, 100);
        axi(1, OFS_DECAY, 1, RESP_OKAY);
        for (int i = 1; i <= 3; i++) smp(50, 100 - i);
        smp(150, 150);
        axi(1, OFS_DECAY, 0, RESP_OKAY);
        axi(1, OFS_TRIG, 500, RESP_OKAY);
        axi(1, OFS_HYST, 20, RESP_OKAY);
        axi(1, OFS_CTRL, 1, RESP_OKAY);
        foreach (av[i]) smp(av[i], ae[i]);
        axi(1, OFS_RMIN, 300, RESP_OKAY);
        axi(1, OFS_CTRL, 3, RESP_OKAY);
        axi(1, OFS_HOLD, 5, RESP_OKAY);
        repeat (80) @(posedge clk);
        smp(200, 200);
        chk(fs, 1);
        axi(1, OFS_HOLD, 0, RESP_OKAY);
        axi(1, OFS_CTRL, 4, RESP_OKAY);
        axi(1, OFS_AVG, 10, RESP_OKAY);
        chk({phi, avi}, 1);
        smp(1000, -1);
        for (int i = 0; i < 3; i++) begin
            o1 = lo;
            smp(1000, -1);
            chk(lo > o1 && lo <= 1000, 1);
        end
        trg();
        smp(200, -1);
        chk(lo > 900, 1);
        {sel, up} <= 2'b11;
        @(posedge clk);
        {sel, up} <= 2'b00;
        axi(0, OFS_AVG, 11, RESP_OKAY);
        finish_test();
    end
endmodule
`default_nettype wire
